// ### flash_self_program_sequencer.sv
// self-programming sequencer: control registers, command window, erase, write, fuse reads
// Operation
// (RULE1) store-to-program ignored unless the self-program fuse input is zero
// (RULE2) software erases a page before writing it; buffer fill before or after erase
// (RULE3) buffer words may be loaded in any order
// (RULE4) control 00000011 then store within four cycles erases the pointer's page
// (RULE5) erase ignores the data pair and pointer bits outside the page field
// (RULE6) core halted for the whole page erase
// (RULE7) control 00000001 then store within four cycles loads data at word field
// (RULE8) buffer cleared after page write, on clear command and on reset
// (RULE9) software never loads one buffer word twice without clearing
// (RULE10) eeprom write start during loading discards the buffer
// (RULE11) control 00000101 then store within four cycles writes the page
// (RULE12) core halted for the whole page write; data pair ignored
// (RULE13) pointer low bits select word, high bits select page, decoded per operation
// (RULE14) load-from-program uses pointer bit zero as byte select
// (RULE15) eeprom write busy blocks all programming and fuse or lock reads
// (RULE16) software checks eeprom busy before writing the control register
// (RULE17) load within three cycles of fuse-read select returns fuse or lock byte
// (RULE18) select and enable clear after the read or when windows expire
// (RULE19) with select and enable clear, loads return flash bytes
// (RULE20) pointer 0001 lock, 0000 fuse low, 0003 fuse high byte
// (RULE21) lock read: second lock bit at bit 1, first at bit 0
// (RULE22) control bits: clear 4, fuse read 3, write 2, erase 1, enable 0
// (RULE23) control writes other than valid commands have no effect
// (RULE24) erase and write last between 3.7 ms and 4.5 ms
// (RULE25) four-cycle window restarts on control write; expiry clears the command
// (RULE26) enable stays set while erase or write is busy; a clear command written in the starting store's cycle clears it
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_defs.svh"
module flash_self_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core instructions
  input wire logic spm_req,
  input wire logic lpm_req,
  output logic core_halt,
  output logic [7:0] lpm_data,
  output logic lpm_valid,
  // fuses, lock bits and eeprom status
  input wire logic self_program_fuse_n,
  input wire logic [1:0] lock_bits,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  input wire logic eeprom_write_busy,
  // flash array
  output logic [9:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_byte,
  output logic flash_erase,
  output logic flash_wr_en,
  output logic [3:0] flash_wr_word,
  output logic [15:0] flash_wr_data,
  output logic [4:0] flash_page
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic mapped(input logic [7:0] a);
    return a == `ADDR_CTRL || a == `ADDR_PTR || a == `ADDR_DATA || a == `ADDR_STAT;
  endfunction

  function automatic logic valid_cmd(input logic [4:0] c);
    return c == `CMD_LOAD || c == `CMD_ERASE || c == `CMD_WRITE || c == `CMD_READ_FUSE_LOCK_SELECT ||
      c == `CMD_CLEAR_BUFFER_CMD;
  endfunction

  function automatic logic [7:0] fuse_byte(input logic [15:0] ptr, input logic [1:0] lb,
    input logic [7:0] flo, input logic [7:0] fhi);
    case (ptr)
      `PTR_LOCK: return {`LOCK_PAD, lb}; // RULE21
      `PTR_FUSE_LO: return flo;
      `PTR_FUSE_HI: return fhi;
      default: return `NO_FUSE_BYTE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [4:0] ctrl;
  logic [15:0] pointer;
  logic [15:0] data_pair;
  logic [2:0] win;
  seq_state_type state;
  logic [3:0] stream_idx;
  logic ee_prev;
  logic op_start;
  logic op_done;
  logic access;
  logic wr_ctrl;
  logic cmd_ok;
  logic idle;
  logic spm_ok;
  logic go_erase;
  logic go_write;
  logic fuse_mode;
  logic [31:0] read_mux;

  page_buf_if bif ();

  page_buffer u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .bif(bif)
  );

  op_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(op_start),
    .done(op_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // command qualification

  assign access = psel && penable && pready;
  assign idle = (state == ST_IDLE);
  // control is frozen while busy or while the eeprom writes
  assign wr_ctrl = access && pwrite && paddr == `ADDR_CTRL && idle && !eeprom_write_busy; // RULE15
  assign cmd_ok = valid_cmd(pwdata[4:0]); // RULE23
  assign spm_ok = spm_req && idle && win != 3'h0 && ctrl[`BIT_SPMEN] &&
    !self_program_fuse_n && !eeprom_write_busy; // RULE1 RULE15
  assign go_erase = spm_ok && ctrl == `CMD_ERASE; // RULE4
  assign go_write = spm_ok && ctrl == `CMD_WRITE; // RULE11
  assign fuse_mode = ctrl == `CMD_READ_FUSE_LOCK_SELECT && win > `LPM_MIN_WIN && !eeprom_write_busy; // RULE17 RULE15
  assign op_start = go_erase || (state == ST_STREAM && stream_idx == `LAST_WORD); // RULE24

  ////////////////////////////////////////////////////////////////////////////////
  // buffer connections

  assign bif.load = spm_ok && ctrl == `CMD_LOAD; // RULE7
  assign bif.load_idx = pointer[`WORD_MSB:`WORD_LSB]; // RULE13 RULE14
  assign bif.load_data = data_pair; // RULE7
  assign bif.rd_idx = stream_idx;
  assign bif.clear = (wr_ctrl && pwdata[4:0] == `CMD_CLEAR_BUFFER_CMD) || // RULE8
    (state == ST_WRITE && op_done) || // RULE8
    (eeprom_write_busy && !ee_prev); // RULE10

  ////////////////////////////////////////////////////////////////////////////////
  // control register and command window

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 5'h00;
      win <= 3'h0;
    end else if (wr_ctrl && cmd_ok) begin
      // clear command acts at once and leaves nothing armed
      ctrl <= (pwdata[4:0] == `CMD_CLEAR_BUFFER_CMD) ? 5'h00 : pwdata[4:0]; // RULE22
      win <= (pwdata[4:0] == `CMD_CLEAR_BUFFER_CMD) ? 3'h0 : `SPM_WINDOW; // RULE25
    end else if (!idle) begin
      win <= 3'h0;
      if (op_done) begin
        ctrl <= 5'h00; // RULE26
      end
    end else if (go_erase || go_write) begin
      win <= 3'h0; // RULE26
    end else if (spm_ok || (lpm_req && fuse_mode) || win == 3'h1) begin
      ctrl <= 5'h00; // RULE18 RULE25
      win <= 3'h0;
    end else if (win != 3'h0) begin
      win <= win - 3'h1; // RULE25
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pointer and data pair

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer <= 16'h0000;
    end else if (access && pwrite && paddr == `ADDR_PTR) begin
      pointer <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_pair <= 16'h0000;
    end else if (access && pwrite && paddr == `ADDR_DATA) begin
      data_pair <= pwdata[15:0];
    end
  end

  assign flash_rd_addr = pointer[`FLASH_ABITS-1:0]; // RULE14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_prev <= 1'b0;
    end else begin
      ee_prev <= eeprom_write_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // erase and write sequence

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go_erase) begin
            state <= ST_ERASE; // RULE4
          end else if (go_write) begin
            state <= ST_STREAM; // RULE11
          end
        end
        ST_STREAM: begin
          if (stream_idx == `LAST_WORD) begin
            state <= ST_WRITE;
          end
        end
        ST_ERASE, ST_WRITE: begin
          if (op_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stream_idx <= 4'h0;
    end else if (state == ST_STREAM) begin
      stream_idx <= stream_idx + 4'h1;
    end else begin
      stream_idx <= 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_halt <= 1'b0;
    end else if (go_erase || go_write) begin
      core_halt <= 1'b1; // RULE6 RULE12
    end else if (op_done) begin
      core_halt <= 1'b0;
    end
  end

  // page latched at the moment each operation starts, data pair never used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_page <= 5'h00;
      flash_erase <= 1'b0;
    end else begin
      flash_erase <= go_erase; // RULE4 RULE5
      if (go_erase || go_write) begin
        flash_page <= pointer[`PAGE_MSB:`PAGE_LSB]; // RULE13 RULE5
      end
    end
  end

  // the whole buffer is streamed; unloaded words go out erased
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_wr_en <= 1'b0;
      flash_wr_word <= 4'h0;
      flash_wr_data <= 16'h0000;
    end else begin
      flash_wr_en <= (state == ST_STREAM); // RULE12
      flash_wr_word <= stream_idx;
      flash_wr_data <= bif.rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // load-from-program answers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpm_valid <= 1'b0;
      lpm_data <= 8'h00;
    end else begin
      lpm_valid <= lpm_req;
      if (lpm_req) begin
        lpm_data <= fuse_mode ? // RULE17 RULE19
          fuse_byte(pointer, lock_bits, fuse_low_byte, fuse_high_byte) : // RULE20
          flash_rd_byte; // RULE14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state

  always_comb begin
    case (paddr)
      `ADDR_CTRL: read_mux = {27'h0, ctrl}; // RULE22
      `ADDR_PTR: read_mux = {16'h0, pointer};
      `ADDR_DATA: read_mux = {16'h0, data_pair};
      `ADDR_STAT: read_mux = {29'h0, bif.any_valid, eeprom_write_busy, !idle};
      default: read_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0 : read_mux;
        pslverr <= !mapped(paddr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_erase_go;
    go_erase;
  endsequence

  sequence s_write_go;
    go_write;
  endsequence

  property p_fuse_block;
    spm_req && self_program_fuse_n && idle |=> idle && !core_halt;
  endproperty
  a_fuse_block: assert property (p_fuse_block) else $error("store ran with fuse off"); // RULE1

  property p_erase_start;
    s_erase_go |=> flash_erase && core_halt && state == ST_ERASE;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase did not start"); // RULE4

  property p_erase_page;
    s_erase_go |=> flash_page == $past(pointer[`PAGE_MSB:`PAGE_LSB]);
  endproperty
  a_erase_page: assert property (p_erase_page) else $error("wrong erase page"); // RULE13

  property p_halt_hold;
    (state == ST_ERASE || state == ST_WRITE) && !op_done |=> core_halt;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("core released early"); // RULE6

  property p_write_stream;
    s_write_go |-> ##2 flash_wr_en [*8] ##0 core_halt;
  endproperty
  a_write_stream: assert property (p_write_stream) else $error("page write stream broken"); // RULE12

  property p_load;
    bif.load && !bif.clear && !wr_ctrl |=> bif.any_valid && ctrl == 5'h00;
  endproperty
  a_load: assert property (p_load) else $error("buffer load wrong"); // RULE7

  property p_window;
    idle && win == 3'h1 && !wr_ctrl && !go_erase && !go_write |=> ctrl == 5'h00 && win == 3'h0;
  endproperty
  a_window: assert property (p_window) else $error("window expiry kept command"); // RULE25

  property p_lock_read;
    lpm_req && fuse_mode && pointer == `PTR_LOCK |=>
      lpm_valid && lpm_data == {`LOCK_PAD, $past(lock_bits)} && ctrl == 5'h00;
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock byte wrong"); // RULE21

  property p_plain_read;
    lpm_req && ctrl == 5'h00 |=> lpm_data == $past(flash_rd_byte);
  endproperty
  a_plain_read: assert property (p_plain_read) else $error("plain load not flash"); // RULE19

  property p_ee_block;
    eeprom_write_busy && idle |=> idle && !core_halt;
  endproperty
  a_ee_block: assert property (p_ee_block) else $error("programming during eeprom write"); // RULE15

  property p_enable_busy;
    !idle |-> ctrl[`BIT_SPMEN];
  endproperty
  a_enable_busy: assert property (p_enable_busy) else $error("enable dropped while busy"); // RULE26

  property p_bad_cmd;
    wr_ctrl && !cmd_ok && win == 3'h0 |=> ctrl == $past(ctrl) && win == 3'h0;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("invalid command took effect"); // RULE23

endmodule
`default_nettype wire

// ### flash_seq_defs.svh
// offsets, field positions, command codes and timing counts of the sequencer
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

`define ADDR_CTRL 8'h00
`define ADDR_PTR 8'h04
`define ADDR_DATA 8'h08
`define ADDR_STAT 8'h0C

`define CMD_LOAD 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_READ_FUSE_LOCK_SELECT 5'h09
`define CMD_CLEAR_BUFFER_CMD 5'h11
`define BIT_SPMEN 0

`define WORD_LSB 1
`define WORD_MSB 4
`define PAGE_LSB 5
`define PAGE_MSB 9
`define FLASH_ABITS 10
`define LAST_WORD 4'hF
`define ERASED_WORD 16'hFFFF

`define SPM_WINDOW 3'h4
`define LPM_MIN_WIN 3'h1

`define PTR_LOCK 16'h0001
`define PTR_FUSE_LO 16'h0000
`define PTR_FUSE_HI 16'h0003
`define LOCK_PAD 6'h3F
`define NO_FUSE_BYTE 8'hFF

`define PROG_TIME_NS 3700000
`define CLK_PERIOD_NS 8
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### flash_seq_pkg.sv
// types shared by the sequencer modules
package flash_seq_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_STREAM, ST_WRITE} seq_state_type;
endpackage

// ### page_buf_if.sv
// link between sequencer control and the temporary page buffer
`timescale 1ns/10ps
`default_nettype none
interface page_buf_if;
  logic load;
  logic [3:0] load_idx;
  logic [15:0] load_data;
  logic clear;
  logic [3:0] rd_idx;
  logic [15:0] rd_data;
  logic any_valid;
  modport ctrl (output load, load_idx, load_data, clear, rd_idx, input rd_data, any_valid);
  modport store (input load, load_idx, load_data, clear, rd_idx, output rd_data, any_valid);
endinterface
`default_nettype wire

// ### page_buffer.sv
// temporary page buffer: one word per location, random order loads
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_defs.svh"
module page_buffer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control side
  page_buf_if.store bif
);
  logic [15:0] mem [16];
  logic [15:0] valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid <= 16'h0000; // RULE8
    end else if (bif.clear) begin
      valid <= 16'h0000; // RULE8
    end else if (bif.load && !valid[bif.load_idx]) begin
      valid[bif.load_idx] <= 1'b1; // RULE3
    end
  end

  // second load to a written word is dropped, first data kept
  always_ff @(posedge pclk) begin
    if (bif.load && !bif.clear && !valid[bif.load_idx]) begin
      mem[bif.load_idx] <= bif.load_data; // RULE3
    end
  end

  assign bif.rd_data = valid[bif.rd_idx] ? mem[bif.rd_idx] : `ERASED_WORD;
  assign bif.any_valid = |valid;

  property p_clear_empty;
    @(posedge pclk) disable iff (!presetn) bif.clear |=> !bif.any_valid;
  endproperty
  a_clear_empty: assert property (p_clear_empty) else $error("buffer not empty after clear"); // RULE8
endmodule
`default_nettype wire

// ### op_timer.sv
// programming timer: one done pulse a fixed count after start
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_defs.svh"
module op_timer #(
  parameter int unsigned CYCLES = `PROG_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      done <= (cnt == W'(1)) && !start; // RULE24
      if (start) begin
        cnt <= W'(CYCLES); // RULE24
      end else if (cnt != '0) begin
        cnt <= cnt - W'(1);
      end
    end
  end

  property p_done_time;
    @(posedge pclk) disable iff (!presetn) done |-> cnt == '0 && $past(cnt) == W'(1);
  endproperty
  a_done_time: assert property (p_done_time) else $error("done not at end of count"); // RULE24
endmodule
`default_nettype wire

// ### flash_array_model.sv
// flash array stand-in: patterned byte reads, records erase and page stream
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sequencer side
  input wire logic core_halt,
  input wire logic [9:0] flash_rd_addr,
  output logic [7:0] flash_rd_byte,
  input wire logic flash_erase,
  input wire logic flash_wr_en,
  input wire logic [3:0] flash_wr_word,
  input wire logic [15:0] flash_wr_data,
  input wire logic [4:0] flash_page
);
  logic [15:0] wr_mem [16];
  logic [4:0] last_page;
  int wr_count;
  int erase_count;
  int halt_run;
  int halt_len;
  int unhalted_ops;
  // byte differs for each value of the low eight address bits, so a wrong byte select shows up
  assign flash_rd_byte = flash_rd_addr[7:0] ^ 8'hA5;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_count <= 0;
      erase_count <= 0;
      halt_run <= 0;
      halt_len <= 0;
      unhalted_ops <= 0;
      last_page <= 5'h00;
    end else begin
      if (flash_erase) begin
        erase_count <= erase_count + 1;
        last_page <= flash_page;
      end
      if (flash_wr_en) begin
        wr_mem[flash_wr_word] <= flash_wr_data;
        wr_count <= wr_count + 1;
        last_page <= flash_page;
      end
      // array activity with the core running would corrupt fetches
      if ((flash_erase || flash_wr_en) && !core_halt) unhalted_ops <= unhalted_ops + 1;
      if (core_halt) begin
        halt_run <= halt_run + 1;
      end else if (halt_run != 0) begin
        halt_len <= halt_run;
        halt_run <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// testbench for the self-programming sequencer
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_defs.svh"
module tb;
  localparam int P = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic spm_req, lpm_req, core_halt, lpm_valid, fuse_n, ee_busy, errv;
  logic [7:0] lpm_data, flo, fhi, rd_byte;
  logic [1:0] lock_bits;
  logic [9:0] rd_addr;
  logic erase, wr_en;
  logic [3:0] wr_word;
  logic [15:0] wr_data;
  logic [4:0] page;
  int fails, tests_run, cyc;
  flash_self_program_sequencer #(.PROG_CYCLES(P)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .spm_req(spm_req),
    .lpm_req(lpm_req), .core_halt(core_halt), .lpm_data(lpm_data), .lpm_valid(lpm_valid),
    .self_program_fuse_n(fuse_n), .lock_bits(lock_bits), .fuse_low_byte(flo),
    .fuse_high_byte(fhi), .eeprom_write_busy(ee_busy), .flash_rd_addr(rd_addr),
    .flash_rd_byte(rd_byte), .flash_erase(erase), .flash_wr_en(wr_en),
    .flash_wr_word(wr_word), .flash_wr_data(wr_data), .flash_page(page));
  flash_array_model flash (.pclk(pclk), .presetn(presetn), .core_halt(core_halt),
    .flash_rd_addr(rd_addr), .flash_rd_byte(rd_byte), .flash_erase(erase),
    .flash_wr_en(wr_en), .flash_wr_word(wr_word), .flash_wr_data(wr_data),
    .flash_page(page));
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; an idle cycle first keeps drivers single per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic store_to_program_instr;
    spm_req <= 1'b1;
    @(posedge pclk);
    spm_req <= 1'b0;
  endtask
  task automatic load_from_program_instr(input logic [7:0] exp);
    lpm_req <= 1'b1;
    @(posedge pclk);
    lpm_req <= 1'b0;
    @(posedge pclk);
    check({31'h0, lpm_valid}, 32'h1);
    check({24'h0, lpm_data}, {24'h0, exp});
  endtask
  task automatic load(input logic [3:0] idx, input logic [15:0] d);
    apb(1'b1, `ADDR_PTR, {22'h0, 5'h03, idx, 1'b0});
    apb(1'b1, `ADDR_DATA, {16'h0, d});
    apb(1'b1, `ADDR_CTRL, 32'h01);
    store_to_program_instr();
  endtask
  // first edge lets a halt launched at the calling edge settle
  task automatic wait_free;
    @(posedge pclk);
    while (core_halt !== 1'b0) begin
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, `ADDR_CTRL, 32'h0);
    check(rdv, 32'h0);
    apb(1'b0, `ADDR_STAT, 32'h0);
    check(rdv, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, errv}, 32'h1);
  endtask
  task automatic t_fuse;
    logic [15:0] ptrs [3];
    logic [7:0] exps [3];
    ptrs = '{16'h0001, 16'h0000, 16'h0003};
    exps = '{{`LOCK_PAD, lock_bits}, flo, fhi};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `ADDR_PTR, {16'h0, ptrs[i]});
      apb(1'b1, `ADDR_CTRL, 32'h09);
      load_from_program_instr(exps[i]);
      apb(1'b0, `ADDR_CTRL, 32'h0);
      check(rdv, 32'h0);
    end
  endtask
  task automatic t_plain;
    apb(1'b1, `ADDR_PTR, 32'h0001);
    apb(1'b1, `ADDR_CTRL, 32'h09);
    repeat (5) @(posedge pclk);
    load_from_program_instr(8'h01 ^ 8'hA5);
    apb(1'b1, `ADDR_PTR, 32'h0002);
    repeat (2) @(posedge pclk);
    load_from_program_instr(8'h02 ^ 8'hA5);
    apb(1'b1, `ADDR_PTR, 32'h0003);
    repeat (2) @(posedge pclk);
    load_from_program_instr(8'h03 ^ 8'hA5);
  endtask
  task automatic t_refuse;
    apb(1'b1, `ADDR_CTRL, 32'h07);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    check(rdv, 32'h0);
    fuse_n <= 1'b1;
    load(4'h1, 16'h1111);
    apb(1'b0, `ADDR_STAT, 32'h0);
    check(rdv, 32'h0);
    fuse_n <= 1'b0;
    apb(1'b1, `ADDR_CTRL, 32'h01);
    repeat (5) @(posedge pclk);
    store_to_program_instr();
    apb(1'b0, `ADDR_STAT, 32'h0);
    check(rdv, 32'h0);
  endtask
  task automatic t_clear;
    apb(1'b0, `ADDR_STAT, 32'h0);
    check({31'h0, rdv[1]}, 32'h0);
    load(4'h4, 16'h4444);
    apb(1'b0, `ADDR_STAT, 32'h0);
    check(rdv, 32'h4);
    apb(1'b1, `ADDR_CTRL, 32'h11);
    apb(1'b0, `ADDR_STAT, 32'h0);
    check(rdv, 32'h0);
    load(4'h5, 16'h5555);
    ee_busy <= 1'b1;
    apb(1'b0, `ADDR_STAT, 32'h0);
    check(rdv, 32'h2);
    load(4'h6, 16'h6666);
    apb(1'b0, `ADDR_STAT, 32'h0);
    check(rdv, 32'h2);
    apb(1'b1, `ADDR_PTR, 32'h0001);
    apb(1'b1, `ADDR_CTRL, 32'h09);
    load_from_program_instr(8'h01 ^ 8'hA5);
    ee_busy <= 1'b0;
  endtask
  task automatic t_erase;
    apb(1'b1, `ADDR_PTR, 32'h007F);
    apb(1'b1, `ADDR_DATA, 32'hBEEF);
    apb(1'b1, `ADDR_CTRL, 32'h03);
    store_to_program_instr();
    apb(1'b0, `ADDR_CTRL, 32'h0);
    check({31'h0, rdv[0]}, 32'h1);
    wait_free();
    check(flash.erase_count, 32'h1);
    check({27'h0, flash.last_page}, 32'h03);
    check(flash.unhalted_ops, 32'h0);
    check({31'h0, flash.halt_len >= P && flash.halt_len <= P + 2}, 32'h1);
  endtask
  task automatic t_write;
    // erase came first and each word is loaded once, as software must
    load(4'h9, 16'h9009);
    load(4'h2, 16'h2002);
    load(4'hF, 16'hF00F);
    apb(1'b1, `ADDR_PTR, 32'h0060);
    apb(1'b1, `ADDR_CTRL, 32'h05);
    store_to_program_instr();
    wait_free();
    check(flash.wr_count, 32'd16);
    check({27'h0, flash.last_page}, 32'h03);
    check({16'h0, flash.wr_mem[9]}, 32'h9009);
    check({16'h0, flash.wr_mem[2]}, 32'h2002);
    check({16'h0, flash.wr_mem[15]}, 32'hF00F);
    check({16'h0, flash.wr_mem[0]}, {16'h0, `ERASED_WORD});
    check(flash.unhalted_ops, 32'h0);
    check({31'h0, flash.halt_len >= P + 16 && flash.halt_len <= P + 19}, 32'h1);
    apb(1'b0, `ADDR_STAT, 32'h0);
    check(rdv, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // a hang ends the run here rather than stalling forever
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    fails = 0;
    tests_run = 0;
    cyc = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, spm_req, lpm_req, fuse_n, ee_busy} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    lock_bits = 2'b10;
    flo = 8'h6A;
    fhi = 8'hF3;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fuse();
    t_plain();
    t_refuse();
    t_clear();
    t_erase();
    t_write();
    tally_and_finish();
  end
endmodule
`default_nettype wire
